// ===== nvm_access_pkg.sv
// Constants shared by the data EEPROM access controller.
// Assumes a 32-bit APB master and one 200 MHz clock.
package nvm_access_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] CTRL_IDX = 8'h3f;
  localparam logic [7:0] DATA_IDX = 8'h40;
  localparam logic [7:0] ADDR_LO_IDX = 8'h41;
  localparam logic [7:0] ADDR_HI_IDX = 8'h42;
  localparam logic [7:0] IRQ_STAT_IDX = 8'h50;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h51;
  // Control register fields.
  localparam int READ_STROBE_BIT = 0;
  localparam int PROG_STROBE_BIT = 1;
  localparam int MASTER_WE_BIT = 2;
  localparam int READY_IE_BIT = 3;
  localparam int MODE_LSB = 4;
  // Interrupt status fields.
  localparam int DONE_BIT = 0;
  localparam int FAIL_BIT = 1;
  localparam int IRQ_BITS = 2;
  // Program mode encodings.
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  // Reset values and the erased byte value.
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [9:0] ADDR_RESET = 10'h000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Timing counts in clock cycles.
  localparam logic [1:0] MWE_LAST = 2'h3;
  localparam logic [2:0] PROG_STALL = 3'h2;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam int WRITE_OSC_CYCLES = 26368;
endpackage

// ===== nvm_access.sv
// Data EEPROM access controller with APB register port and write timer.
// Assumes osc_clk is the free running calibrated oscillator, far slower than pclk.
//
// Notes on behaviour
// - Program strobe flag clears itself when the write time has elapsed.
// - Accepted program strobe stalls the CPU for two cycles, or four if a read strobe is written with it.
// - Strobe arriving after the master enable window lapsed does not write.
// - Read strobe loads the byte at the held address into data register.
// - Every accepted read stalls the CPU for four cycles.
// - During a write, read strobes are ignored and address writes blocked.
// - A write lasts 26,368 calibrated oscillator cycles, about 3.3 ms.
// - Master write enable clears itself four cycles after being set.
// - Strobe starts a write only within four cycles of master enable.
// - Mode field selects atomic, erase only, write only; 11 reserved.
// - Ready interrupt holds high while enabled and strobe flag is clear.
module nvm_access
  import nvm_access_pkg::*;
#(
  parameter int ADDR_WIDTH = 9,
  parameter int WRITE_CYCLES = WRITE_OSC_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_clk,
  output logic cpu_stall,
  output logic ready_irq,
  output logic irq
);
  logic [7:0] mem [0:(1 << ADDR_WIDTH) - 1];
  logic [9:0] nvm_address_reg;
  logic [7:0] nvm_data_reg;
  logic [1:0] program_mode_field;
  logic ready_irq_enable;
  logic master_write_enable;
  logic program_strobe_flag;
  logic [1:0] mwe_count_reg;
  logic [2:0] stall_reg;
  logic [14:0] osc_count_reg;
  logic [ADDR_WIDTH-1:0] op_addr_reg;
  logic [7:0] op_data_reg;
  logic [1:0] op_mode_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic osc_tick;
  logic [7:0] idx;
  logic mapped;
  logic wr_en;
  logic ctrl_wr;
  logic rd_go;
  logic pe_req;
  logic pe_go;
  logic pe_fail;
  logic wr_done;
  logic [7:0] rd_byte;

  assign idx = paddr[9:2];
  assign mapped = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 &&
                  (idx == CTRL_IDX || idx == DATA_IDX || idx == ADDR_LO_IDX ||
                   idx == ADDR_HI_IDX || idx == IRQ_STAT_IDX || idx == IRQ_MASK_IDX);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign ctrl_wr = wr_en && idx == CTRL_IDX;
  assign rd_byte = mem[nvm_address_reg[ADDR_WIDTH-1:0]];
  assign rd_go = ctrl_wr && pwdata[READ_STROBE_BIT] && !program_strobe_flag;
  assign pe_req = ctrl_wr && pwdata[PROG_STROBE_BIT] && !program_strobe_flag;
  assign pe_go = pe_req && master_write_enable && program_mode_field != MODE_RESERVED;
  assign pe_fail = pe_req && !pe_go;
  assign wr_done = program_strobe_flag && osc_tick &&
                   osc_count_reg == 15'(WRITE_CYCLES - 1);
  assign osc_tick = osc_s2_reg && !osc_s3_reg;
  assign ready_irq = ready_irq_enable && !program_strobe_flag;
  assign irq = |(irq_stat_reg & irq_mask_reg);
  assign cpu_stall = stall_reg != 3'h0;

  // Oscillator edges cross into the CPU clock through two flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_clk;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  // Read data is captured in the setup phase and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (idx)
        CTRL_IDX: prdata <= {26'h0, program_mode_field, ready_irq_enable,
                             master_write_enable, program_strobe_flag, 1'b0};
        DATA_IDX: prdata <= {24'h0, nvm_data_reg};
        ADDR_LO_IDX: prdata <= {24'h0, nvm_address_reg[7:0]};
        ADDR_HI_IDX: prdata <= {30'h0, nvm_address_reg[9:8]};
        IRQ_STAT_IDX: prdata <= {30'h0, irq_stat_reg};
        IRQ_MASK_IDX: prdata <= {30'h0, irq_mask_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Address is frozen while a write is in progress.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_address_reg <= ADDR_RESET;
    end else if (wr_en && !program_strobe_flag) begin
      if (idx == ADDR_LO_IDX) begin
        nvm_address_reg[7:0] <= pwdata[7:0];
      end else if (idx == ADDR_HI_IDX) begin
        nvm_address_reg[9:8] <= pwdata[1:0];
      end
    end
  end

  // Data register takes software writes and read results.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_data_reg <= DATA_RESET;
    end else if (rd_go) begin
      nvm_data_reg <= rd_byte;
    end else if (wr_en && idx == DATA_IDX) begin
      nvm_data_reg <= pwdata[7:0];
    end
  end

  // Mode and ready enable; mode writes are ignored while busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_mode_field <= MODE_ATOMIC;
      ready_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      ready_irq_enable <= pwdata[READY_IE_BIT];
      if (!program_strobe_flag) begin
        program_mode_field <= pwdata[MODE_LSB +: 2];
      end
    end
  end

  // Master write enable opens a four cycle window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_write_enable <= 1'b0;
      mwe_count_reg <= 2'h0;
    end else if (ctrl_wr && pwdata[MASTER_WE_BIT] && !master_write_enable) begin
      master_write_enable <= 1'b1;
      mwe_count_reg <= 2'h0;
    end else if (master_write_enable) begin
      if (mwe_count_reg == MWE_LAST) begin
        master_write_enable <= 1'b0;
      end
      mwe_count_reg <= mwe_count_reg + 2'h1;
    end
  end

  // CPU stall counter for strobes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_reg <= 3'h0;
    end else if (rd_go) begin
      stall_reg <= READ_STALL;
    end else if (pe_go) begin
      stall_reg <= PROG_STALL;
    end else if (stall_reg != 3'h0) begin
      stall_reg <= stall_reg - 3'h1;
    end
  end

  // Write timer counts synchronised oscillator cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_strobe_flag <= 1'b0;
      osc_count_reg <= 15'h0000;
      op_addr_reg <= '0;
      op_data_reg <= 8'h00;
      op_mode_reg <= MODE_ATOMIC;
    end else if (pe_go) begin
      program_strobe_flag <= 1'b1;
      osc_count_reg <= 15'h0000;
      op_addr_reg <= nvm_address_reg[ADDR_WIDTH-1:0];
      op_data_reg <= nvm_data_reg;
      op_mode_reg <= program_mode_field;
    end else if (wr_done) begin
      program_strobe_flag <= 1'b0;
    end else if (program_strobe_flag && osc_tick) begin
      osc_count_reg <= osc_count_reg + 15'h0001;
    end
  end

  // Cell array update at the end of the write time.
  always_ff @(posedge pclk) begin
    if (wr_done) begin
      case (op_mode_reg)
        MODE_ATOMIC: mem[op_addr_reg] <= op_data_reg;
        MODE_ERASE: mem[op_addr_reg] <= ERASED_BYTE;
        MODE_WRITE: mem[op_addr_reg] <= mem[op_addr_reg] & op_data_reg;
        default: mem[op_addr_reg] <= mem[op_addr_reg];
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_en && idx == IRQ_STAT_IDX) ?
                       pwdata[IRQ_BITS-1:0] : 2'h0)) | {pe_fail, wr_done};
      if (wr_en && idx == IRQ_MASK_IDX) begin
        irq_mask_reg <= pwdata[IRQ_BITS-1:0];
      end
    end
  end

  // Oscillator ticks seen during a write, counted apart from the timer for checking.
  logic [15:0] ticks_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks_seen_reg <= 16'h0000;
    end else if (pe_go) begin
      ticks_seen_reg <= 16'h0000;
    end else if (program_strobe_flag && osc_tick) begin
      ticks_seen_reg <= ticks_seen_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Rule checks and scenario covers.
  mwe_window_a: assert property ($rose(master_write_enable) |->
    master_write_enable[*4] ##1 !master_write_enable) else $error("mwe window wrong");
  strobe_stall_a: assert property (pe_go && !rd_go |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("strobe stall wrong");
  read_stall_a: assert property (rd_go |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall wrong");
  read_data_a: assert property (rd_go |=> nvm_data_reg == $past(rd_byte))
    else $error("read data wrong");
  busy_addr_a: assert property (program_strobe_flag |=> $stable(nvm_address_reg))
    else $error("address changed while busy");
  no_window_a: assert property (pe_req && !master_write_enable |=>
    !program_strobe_flag && irq_stat_reg[FAIL_BIT]) else $error("write without window");
  ready_irq_a: assert property (program_strobe_flag |-> !ready_irq)
    else $error("ready irq while busy");
  write_end_a: assert property (wr_done |=> !program_strobe_flag &&
    irq_stat_reg[DONE_BIT]) else $error("write end wrong");
  osc_start_a: assert property ($rose(program_strobe_flag) |->
    osc_count_reg == 15'h0000) else $error("timer not cleared");
  write_len_a: assert property (
    $fell(program_strobe_flag) |-> ticks_seen_reg == 16'(WRITE_CYCLES))
    else $error("write length wrong");
  flag_hold_a: assert property (
    program_strobe_flag && !wr_done |=> program_strobe_flag)
    else $error("strobe flag dropped early");
  busy_read_a: assert property (
    ctrl_wr && pwdata[READ_STROBE_BIT] && program_strobe_flag |=> $stable(nvm_data_reg))
    else $error("read taken while busy");
  read_go_a: assert property (
    ctrl_wr && pwdata[READ_STROBE_BIT] && !program_strobe_flag |=>
    cpu_stall && nvm_data_reg == $past(rd_byte)) else $error("read strobe not taken");
  window_used_a: assert property (
    $rose(program_strobe_flag) |-> $past(master_write_enable))
    else $error("write began without window");
  reserved_mode_a: assert property (
    pe_req && program_mode_field == MODE_RESERVED |=> !program_strobe_flag)
    else $error("reserved mode started a write");
  ready_back_a: assert property (
    wr_done && ready_irq_enable && !ctrl_wr |=> ready_irq)
    else $error("ready irq missing after write");
  mwe_set_a: assert property (
    ctrl_wr && pwdata[MASTER_WE_BIT] && !master_write_enable |=> master_write_enable)
    else $error("master enable not set");
  stall_idle_a: assert property (
    !cpu_stall && !rd_go && !pe_go |=> !cpu_stall)
    else $error("stall without strobe");
  write_cov: cover property (pe_go ##[1:1000] wr_done);
  read_cov: cover property (rd_go);
  fail_cov: cover property (pe_fail);
  busy_read_cov: cover property (ctrl_wr && pwdata[READ_STROBE_BIT] && program_strobe_flag);
  reserved_cov: cover property (pe_req && program_mode_field == MODE_RESERVED);
endmodule // nvm_access

// ===== cpu_model.sv
// CPU core model that issues APB transfers one at a time.
// Assumes one pclk domain and a slave that may stretch the access phase.
module cpu_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Transfers never overlap and no self programming runs, so no access breaks another.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // cpu_model

// ===== tb_eeprom_access_control.sv
// Testbench for the data EEPROM access controller.
// Assumes the CPU model in cpu_model.sv and a shortened write time.
module tb_eeprom_access_control import nvm_access_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, osc_clk = 1'b0, psel, penable, pwrite, e, pready;
  logic pslverr, cpu_stall, ready_irq, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r32;
  logic [7:0] r8;
  int bad_count = 0, tests_run = 0, cyc = 0, n;
  logic [1:0] mt [3] = '{MODE_WRITE, MODE_ERASE, MODE_ATOMIC};
  logic [7:0] dt [3] = '{8'h0f, 8'h11, 8'h96};
  logic [7:0] et [3] = '{8'h0c, 8'hff, 8'h96};
  always #2.5 pclk = ~pclk;
  always #27 osc_clk = ~osc_clk;
  nvm_access #(.WRITE_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk), .cpu_stall(cpu_stall),
    .ready_irq(ready_irq), .irq(irq));
  cpu_model cpu_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
    tests_run++;
    if (g !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    cpu_u.xfer(1'b1, {2'h0, i, 2'h0}, {24'h0, d}, r32, e);
  endtask
  task rd(input logic [7:0] i);
    cpu_u.xfer(1'b0, {2'h0, i, 2'h0}, 32'h0, r32, e);
    r8 = r32[7:0];
  endtask
  task stalls;
    n = 0;
    repeat (8) begin
      @(negedge pclk);
      if (cpu_stall === 1'b1) n++;
    end
  endtask
  task wait_idle;
    r8 = 8'h02;
    for (int j = 0; j < 300 && r8[1] !== 1'b0; j++) rd(CTRL_IDX);
    chk("flag clear", 8'h00, {7'h0, r8[1]});
  endtask
  task prog(input logic [1:0] m, input logic [7:0] d, input logic [7:0] x);
    wr(DATA_IDX, d);
    wr(CTRL_IDX, {2'h0, m, 4'h4} | x);
    wr(CTRL_IDX, {2'h0, m, 4'h2} | x);
  endtask
  task read_byte(input logic [7:0] ex);
    wr(CTRL_IDX, 8'h01);
    stalls;
    chk("read stall", 8'h04, n[7:0]);
    rd(DATA_IDX);
    chk("array byte", ex, r8);
    chk("no error", 8'h00, {7'h0, e});
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("reset outs", 8'h00, {5'h0, cpu_stall, irq, ready_irq});
    rd(CTRL_IDX);
    chk("ctrl reset", 8'h00, r8 & 8'h3f);
    rd(DATA_IDX);
    chk("data reset", DATA_RESET, r8);
    wr(ADDR_LO_IDX, 8'h05);
    wr(ADDR_HI_IDX, 8'h00);
    prog(MODE_ATOMIC, 8'h3c, 8'h08);
    stalls;
    chk("prog stall", 8'h02, n[7:0]);
    chk("ready busy", 8'h00, {7'h0, ready_irq});
    wr(ADDR_LO_IDX, 8'h77);
    rd(ADDR_LO_IDX);
    chk("addr held", 8'h05, r8);
    wr(CTRL_IDX, 8'h09);
    stalls;
    chk("read ignored", 8'h00, n[7:0]);
    wait_idle;
    @(negedge pclk);
    chk("ready idle", 8'h01, {7'h0, ready_irq});
    rd(IRQ_STAT_IDX);
    chk("done bit", 8'h01, r8 & 8'h03);
    chk("irq masked", 8'h00, {7'h0, irq});
    wr(IRQ_MASK_IDX, 8'h03);
    @(negedge pclk);
    chk("irq on", 8'h01, {7'h0, irq});
    wr(IRQ_STAT_IDX, 8'h01);
    @(negedge pclk);
    chk("irq off", 8'h00, {7'h0, irq});
    for (int k = 0; k < 3; k++) begin
      prog(mt[k], dt[k], 8'h00);
      wait_idle;
      read_byte(et[k]);
    end
    wr(IRQ_STAT_IDX, 8'h03);
    prog(MODE_RESERVED, 8'h00, 8'h00);
    rd(IRQ_STAT_IDX);
    chk("reserved refused", 8'h02, r8 & 8'h03);
    wr(IRQ_STAT_IDX, 8'h03);
    wr(CTRL_IDX, 8'h04);
    repeat (5) @(posedge pclk);
    rd(CTRL_IDX);
    chk("mwe cleared", 8'h00, r8 & 8'h06);
    wr(CTRL_IDX, 8'h02);
    rd(IRQ_STAT_IDX);
    chk("late strobe", 8'h02, r8 & 8'h03);
    read_byte(8'h96);
    cpu_u.xfer(1'b0, 12'h3f0, 32'h0, r32, e);
    chk("unmapped", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, r32[7:0]);
    end_of_test;
  end
endmodule // tb_eeprom_access_control
